// File: verilog/dcsw_defs.svh
// Constants for the drive command/state word block: offsets, fields, resets.
// Assumes a 32-bit classic Wishbone register bus; included by bare name.
// Overview of operation
// - Command bits 1..0 pick one of four preset references.
// - Command bit 2 low brakes by DC and stops; high means normal ramping.
// - Command bit 3 low coasts at once; high allows a start.
// - Command bit 4 low ramps down using the quick-stop ramp.
// - Command bit 5 low freezes output frequency; only digital inputs move it.
// - During freeze only coast, DC brake or their digital inputs stop the motor.
// - Command bit 6 low ramps to stop; high permits a start.
// - Trip reset happens only on a rising edge of command bit 7.
// - Command bit 8 high selects the jog speed setting.
// - Command bit 9 picks ramp set one or two.
// - Command words with bit 10 low are ignored entirely.
// - Bit 11 drives relay one only when that relay follows it.
// - Bit 12 drives relay two only when that relay follows it.
// - Bits 14..13 pick the parameter set-up when multi set-up is on.
// - Bit 15 reverses only for serial, OR or AND reversing source.
// - State bit 0 is control ready, bit 1 ready with coast active.
// - State bit 2 start enable, bit 7 warning, bit 5 unused.
// - State bits 3, 4, 6 flag trip, error, locked trip.
// - State bit 8 is one only when speed equals reference.
// - State bit 9 is one when bus control is accepted.
// - State bit 10 within speed limits, bit 11 in operation.
// - State bit 12 flags temporary over-temperature stop with auto restart.
// - State bit 13 flags DC link voltage, bit 14 torque limit.
// - Lost link forces the whole state word to zero.
`ifndef DCSW_DEFS_SVH
`define DCSW_DEFS_SVH

`define DCSW_ADR_W       8
`define DCSW_OFF_CMD     8'h00
`define DCSW_OFF_STATE   8'h04
`define DCSW_OFF_CFG     8'h08
`define DCSW_OFF_ACCEPT  8'h0c

`define DCSW_CMD_RST     16'h0000
`define DCSW_CFG_RST     7'h00
`define DCSW_CMD_VALID   10

`define DCSW_CFG_REL1    0
`define DCSW_CFG_REL2    1
`define DCSW_CFG_MULTI   2
`define DCSW_CFG_REV_LO  3
`define DCSW_CFG_REV_HI  4
`define DCSW_CFG_SET_LO  5
`define DCSW_CFG_SET_HI  6

`endif

// File: verilog/dcsw_pkg.sv
// Types for the drive command/state word block.
// Assumes the constants header is compiled alongside.
package dcsw_pkg;

  // Received command word, bit 15 first
  typedef struct packed {
    logic       reverse;
    logic [1:0] setup;
    logic       relay2;
    logic       relay1;
    logic       valid;
    logic       ramp2;
    logic       jog;
    logic       trip_reset;
    logic       start;
    logic       use_ramp;
    logic       no_quick;
    logic       no_coast;
    logic       ramp_dc;
    logic [1:0] preset;
  } dcsw_cmd_t;

  // Reversing source choices
  typedef enum logic [1:0] {
    DCSW_REV_DIGITAL,
    DCSW_REV_SERIAL,
    DCSW_REV_OR,
    DCSW_REV_AND
  } dcsw_rev_t;

  // Conditions reported by the drive core and digital inputs
  typedef struct packed {
    logic ctrl_ready;
    logic tripped;
    logic start_ready;
    logic error_no_trip;
    logic triplock;
    logic warning;
    logic speed_match;
    logic local_ctrl;
    logic local_stop;
    logic freq_in_limits;
    logic start_signal;
    logic freq_nonzero;
    logic overtemp_hold;
    logic volt_bad;
    logic torque_over;
    logic timer_over;
    logic link_lost;
    logic di_coast;
    logic di_dc_brake;
    logic di_reverse;
  } dcsw_drv_t;

  // Decoded controls toward the motor control core
  typedef struct packed {
    logic [1:0] preset_idx;
    logic       dc_brake;
    logic       coast;
    logic       quick_stop;
    logic       freeze;
    logic       ramp_stop;
    logic       run_permit;
    logic       trip_reset;
    logic       jog;
    logic       ramp_set2;
    logic       relay1;
    logic       relay2;
    logic [1:0] setup_idx;
    logic       reverse;
  } dcsw_ctl_t;

endpackage

// File: verilog/dcsw_core.sv
// Drive command word decoder and state word builder behind a Wishbone slave.
// Assumes a classic Wishbone master, drive conditions synchronous to clk_i.
`timescale 1ns/1ps
`include "dcsw_defs.svh"

module dcsw_core (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`DCSW_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire dcsw_pkg::dcsw_drv_t     drv_i,
  output dcsw_pkg::dcsw_ctl_t          ctl_o,
  output logic      [15:0]             state_word_o
);
  import dcsw_pkg::*;

  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  dcsw_cmd_t   cmd_q;
  dcsw_cmd_t   cmd_d;
  logic [6:0]  cfg_q;
  logic [6:0]  cfg_d;
  logic        prev_rst_q;
  logic        prev_rst_d;
  dcsw_ctl_t   ctl_q;
  dcsw_ctl_t   ctl_d;
  logic [15:0] st_q;
  logic [15:0] st_d;
  logic        req;
  logic        wr_cmd;
  dcsw_cmd_t   wr_word;
  dcsw_rev_t   rev_src;

  // New request: ack_q blocks a second take of the same held cycle
  assign req     = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_word = dcsw_cmd_t'(wb_dat_i[15:0]);
  // Both low lanes needed, so a word is never applied half old, half new
  assign wr_cmd  = req && wb_we_i && (wb_adr_i == `DCSW_OFF_CMD)
                   && wb_sel_i[0] && wb_sel_i[1];
  assign rev_src = dcsw_rev_t'(cfg_q[`DCSW_CFG_REV_HI:`DCSW_CFG_REV_LO]);

  // Bus slave: registered ack one cycle after the request, read data alongside
  always_comb begin
    ack_d  = req;
    rdat_d = 32'h0000_0000;
    cfg_d  = cfg_q;
    if (req && !wb_we_i) begin
      if (wb_adr_i == `DCSW_OFF_STATE) begin
        rdat_d = {16'h0000, st_q};
      end else if (wb_adr_i == `DCSW_OFF_CFG) begin
        rdat_d = {25'h000_0000, cfg_q};
      end else if (wb_adr_i == `DCSW_OFF_ACCEPT) begin
        rdat_d = {16'h0000, cmd_q};
      end else begin
        rdat_d = 32'h0000_0000;    // Unmapped and write-only read zero
      end
    end else if (req && wb_we_i && wb_adr_i == `DCSW_OFF_CFG && wb_sel_i[0]) begin
      cfg_d = wb_dat_i[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
      cfg_q  <= `DCSW_CFG_RST;
    end else if (ce_i) begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
      cfg_q  <= cfg_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Command capture: invalid words leave every control untouched
  always_comb begin
    cmd_d      = cmd_q;
    prev_rst_d = cmd_q.trip_reset;
    if (wr_cmd && wb_dat_i[`DCSW_CMD_VALID]) begin
      cmd_d = wr_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q      <= dcsw_cmd_t'(`DCSW_CMD_RST);
      prev_rst_q <= 1'b0;
    end else if (ce_i) begin
      cmd_q      <= cmd_d;
      prev_rst_q <= prev_rst_d;
    end
  end

  // Decode of the accepted word; reset loads every control low, then the reset word decodes to a coasting stop
  always_comb begin
    ctl_d            = '0;
    ctl_d.preset_idx = cmd_q.preset;
    ctl_d.dc_brake   = !cmd_q.ramp_dc || drv_i.di_dc_brake;
    ctl_d.coast      = !cmd_q.no_coast || drv_i.di_coast;
    ctl_d.freeze     = !cmd_q.use_ramp;
    // Freeze blocks ramp-type stops; coast and DC brake still act
    ctl_d.quick_stop = !cmd_q.no_quick && cmd_q.use_ramp;
    ctl_d.ramp_stop  = !cmd_q.start && cmd_q.use_ramp;
    ctl_d.run_permit = cmd_q.ramp_dc && cmd_q.no_coast && cmd_q.no_quick
                       && cmd_q.start && !drv_i.di_coast
                       && !drv_i.di_dc_brake;
    ctl_d.trip_reset = cmd_q.trip_reset && !prev_rst_q;
    ctl_d.jog        = cmd_q.jog;
    ctl_d.ramp_set2  = cmd_q.ramp2;
    ctl_d.relay1     = cmd_q.relay1 && cfg_q[`DCSW_CFG_REL1];
    ctl_d.relay2     = cmd_q.relay2 && cfg_q[`DCSW_CFG_REL2];
    if (cfg_q[`DCSW_CFG_MULTI]) begin
      ctl_d.setup_idx = cmd_q.setup;
    end else begin
      ctl_d.setup_idx = cfg_q[`DCSW_CFG_SET_HI:`DCSW_CFG_SET_LO];
    end
    case (rev_src)
      DCSW_REV_SERIAL: ctl_d.reverse = cmd_q.reverse;
      DCSW_REV_OR:     ctl_d.reverse = cmd_q.reverse || drv_i.di_reverse;
      DCSW_REV_AND:    ctl_d.reverse = cmd_q.reverse && drv_i.di_reverse;
      default:         ctl_d.reverse = drv_i.di_reverse;
    endcase
  end

  // State word assembly
  always_comb begin
    st_d     = 16'h0000;
    st_d[0]  = drv_i.ctrl_ready && !drv_i.tripped;
    st_d[1]  = drv_i.ctrl_ready && !drv_i.tripped
               && (drv_i.di_coast || !cmd_q.no_coast);
    st_d[2]  = drv_i.start_ready && !ctl_q.coast;
    st_d[3]  = drv_i.tripped;
    st_d[4]  = drv_i.error_no_trip;
    st_d[6]  = drv_i.triplock;
    st_d[7]  = drv_i.warning;
    st_d[8]  = drv_i.speed_match;
    st_d[9]  = !drv_i.local_ctrl && !drv_i.local_stop;
    st_d[10] = drv_i.freq_in_limits;
    st_d[11] = drv_i.start_signal || drv_i.freq_nonzero;
    st_d[12] = drv_i.overtemp_hold;
    st_d[13] = drv_i.volt_bad;
    st_d[14] = drv_i.torque_over;
    st_d[15] = drv_i.timer_over;
    if (drv_i.link_lost) begin
      st_d = 16'h0000;
    end
  end

  // Controls and state register together, one cycle after their inputs; state bit 2 lags coast by one more
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= '0;
      st_q  <= 16'h0000;
    end else if (ce_i) begin
      ctl_q <= ctl_d;
      st_q  <= st_d;
    end
  end

  assign ctl_o        = ctl_q;
  assign state_word_o = st_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence bus_req_s;
    ce_i && req;
  endsequence

  sequence ack_pulse_s;
    wb_ack_o;
  endsequence

  // Trip reset edge seen by the decoder: new bit 7 high, previous low
  sequence trip_rise_s;
    ce_i && cmd_q.trip_reset && !prev_rst_q;
  endsequence

  // Bit 7 held high across accepted words: must not reset again
  sequence trip_steady_s;
    ce_i && cmd_q.trip_reset && prev_rst_q;
  endsequence

  // Link healthy, so state bits carry the drive conditions
  sequence link_ok_s;
    ce_i && !drv_i.link_lost;
  endsequence

  // Bus slave behaviour
  bus_ack_a: assert property (bus_req_s |=> ack_pulse_s)
    else $error("Bus request not acknowledged next cycle");

  ack_once_a: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge stood for more than one cycle");

  cfg_write_a: assert property (ce_i && req && wb_we_i && wb_adr_i == `DCSW_OFF_CFG
                                && wb_sel_i[0] |=> cfg_q == $past(wb_dat_i[6:0]))
    else $error("Configuration write did not land");

  state_read_a: assert property (ce_i && req && !wb_we_i && wb_adr_i == `DCSW_OFF_STATE
                                 |=> wb_dat_o == {16'h0000, $past(st_q)})
    else $error("State read returned wrong data");

  // Enable low must hold every piece of state, the handshake included
  ce_hold_a: assert property (!ce_i |=> $stable(cmd_q) && $stable(ctl_o)
                              && $stable(state_word_o) && $stable(wb_ack_o))
    else $error("State moved while clock enable was low");

  // Command capture
  cmd_ignore_a: assert property (ce_i && wr_cmd && !wb_dat_i[10] |=> $stable(cmd_q))
    else $error("Invalid command word was applied");

  cmd_take_a: assert property (ce_i && wr_cmd && wb_dat_i[10]
                               |=> cmd_q == $past(wb_dat_i[15:0]))
    else $error("Valid command word not captured whole");

  // Decoded controls
  preset_map_a: assert property (ce_i |=> ctl_o.preset_idx == $past(cmd_q.preset))
    else $error("Preset index does not follow command");

  dc_brake_a: assert property (ce_i && !cmd_q.ramp_dc |=> ctl_o.dc_brake)
    else $error("DC brake bit low did not brake");

  dc_release_a: assert property (ce_i && cmd_q.ramp_dc && !drv_i.di_dc_brake
                                 |=> !ctl_o.dc_brake)
    else $error("DC brake active with ramp selected");

  coast_stop_a: assert property (ce_i && !cmd_q.no_coast |=> ctl_o.coast
                                 && !ctl_o.run_permit)
    else $error("Coast bit did not stop the output");

  coast_release_a: assert property (ce_i && cmd_q.no_coast && !drv_i.di_coast
                                    |=> !ctl_o.coast)
    else $error("Coast active without any coast request");

  quick_stop_a: assert property (ce_i && !cmd_q.no_quick && cmd_q.use_ramp
                                 |=> ctl_o.quick_stop)
    else $error("Quick stop bit low did not stop");

  freeze_hold_a: assert property (ce_i && cmd_q.use_ramp |=> !ctl_o.freeze)
    else $error("Output frozen with ramp selected");

  freeze_stop_a: assert property (ce_i && !cmd_q.use_ramp
                                  |=> ctl_o.freeze && !ctl_o.quick_stop
                                  && !ctl_o.ramp_stop)
    else $error("Ramp stop accepted during freeze");

  ramp_stop_a: assert property (ce_i && !cmd_q.start && cmd_q.use_ramp
                                |=> ctl_o.ramp_stop)
    else $error("Ramp stop bit low did not stop");

  run_permit_a: assert property (ce_i && cmd_q.ramp_dc && cmd_q.no_coast && cmd_q.no_quick
                                 && cmd_q.start && !drv_i.di_coast && !drv_i.di_dc_brake
                                 |=> ctl_o.run_permit)
    else $error("Start not permitted with all bits set");

  reset_edge_a: assert property (ctl_o.trip_reset |-> ##0 cmd_q.trip_reset
                                 ##1 !ctl_o.trip_reset || !$past(ce_i))
    else $error("Trip reset not a single edge pulse");

  trip_pulse_a: assert property (trip_rise_s |=> ctl_o.trip_reset)
    else $error("Rising reset bit gave no trip reset");

  trip_steady_a: assert property (trip_steady_s |=> !ctl_o.trip_reset)
    else $error("Steady reset bit reset a trip again");

  trip_low_a: assert property (ce_i && !cmd_q.trip_reset |=> !ctl_o.trip_reset)
    else $error("Trip reset with reset bit low");

  jog_select_a: assert property (ce_i |=> ctl_o.jog == $past(cmd_q.jog))
    else $error("Jog control does not follow command");

  ramp_set_a: assert property (ce_i |=> ctl_o.ramp_set2 == $past(cmd_q.ramp2))
    else $error("Ramp set does not follow command");

  relay_gate_a: assert property (ce_i && !cfg_q[0] |=> !ctl_o.relay1)
    else $error("Relay one driven without follow setting");

  relay_follow_a: assert property (ce_i && cfg_q[0]
                                   |=> ctl_o.relay1 == $past(cmd_q.relay1))
    else $error("Relay one ignores its command bit");

  relay_two_a: assert property (ce_i && !cfg_q[1] |=> !ctl_o.relay2)
    else $error("Relay two driven without follow setting");

  relay_two_follow_a: assert property (ce_i && cfg_q[1]
                                       |=> ctl_o.relay2 == $past(cmd_q.relay2))
    else $error("Relay two ignores its command bit");

  setup_sel_a: assert property (ce_i && cfg_q[2] |=> ctl_o.setup_idx == $past(cmd_q.setup))
    else $error("Set-up index not taken from command");

  setup_fixed_a: assert property (ce_i && !cfg_q[2]
                                  |=> ctl_o.setup_idx == $past(cfg_q[6:5]))
    else $error("Set-up index moved without multi set-up");

  reverse_src_a: assert property (ce_i && rev_src == DCSW_REV_DIGITAL
                                  |=> ctl_o.reverse == $past(drv_i.di_reverse))
    else $error("Reverse ignored digital source");

  reverse_ser_a: assert property (ce_i && rev_src == DCSW_REV_SERIAL
                                  |=> ctl_o.reverse == $past(cmd_q.reverse))
    else $error("Reverse ignored serial source");

  // State word bits
  trip_ready_a: assert property (ce_i && drv_i.tripped
                                 |=> !state_word_o[0] && !state_word_o[1])
    else $error("Ready reported while tripped");

  coast_enable_a: assert property (ce_i && ctl_o.coast |=> !state_word_o[2])
    else $error("Enable reported while coasting");

  warn_flag_a: assert property (link_ok_s |=> state_word_o[7] == $past(drv_i.warning))
    else $error("Warning bit does not follow condition");

  spare_bit_a: assert property (ce_i |=> !state_word_o[5])
    else $error("Unused state bit was set");

  trip_flag_a: assert property (link_ok_s |=> state_word_o[3] == $past(drv_i.tripped))
    else $error("Trip bit does not follow condition");

  error_flag_a: assert property (link_ok_s
                                 |=> state_word_o[4] == $past(drv_i.error_no_trip))
    else $error("Error bit does not follow condition");

  lock_flag_a: assert property (link_ok_s |=> state_word_o[6] == $past(drv_i.triplock))
    else $error("Triplock bit does not follow condition");

  speed_flag_a: assert property (link_ok_s
                                 |=> state_word_o[8] == $past(drv_i.speed_match))
    else $error("Speed match bit does not follow condition");

  bus_ctrl_a: assert property (ce_i && (drv_i.local_ctrl || drv_i.local_stop)
                               |=> !state_word_o[9])
    else $error("Bus control reported under local control");

  freq_limit_a: assert property (link_ok_s
                                 |=> state_word_o[10] == $past(drv_i.freq_in_limits))
    else $error("Frequency limit bit does not follow condition");

  in_oper_a: assert property (link_ok_s && (drv_i.start_signal || drv_i.freq_nonzero)
                              |=> state_word_o[11])
    else $error("Operation not reported while running");

  auto_start_a: assert property (link_ok_s
                                 |=> state_word_o[12] == $past(drv_i.overtemp_hold))
    else $error("Over-temperature hold bit does not follow");

  volt_flag_a: assert property (link_ok_s |=> state_word_o[13] == $past(drv_i.volt_bad))
    else $error("Voltage bit does not follow condition");

  torque_flag_a: assert property (link_ok_s
                                  |=> state_word_o[14] == $past(drv_i.torque_over))
    else $error("Torque bit does not follow condition");

  link_lost_a: assert property (ce_i && drv_i.link_lost |=> state_word_o == 16'h0000)
    else $error("State word not cleared on link loss");

endmodule

// File: tb/dcsw_wb_master.sv
// Fieldbus master model: issues classic Wishbone single cycles.
// Assumes the slave acks every request; the bench calls xfer.
`timescale 1ns/1ps
module dcsw_wb_master (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // One request, held until ack is sampled high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    // No own limit: only the bench watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    // Released data flips so a stale word never looks live
    dat_o <= ~d;
  endtask
endmodule

// File: tb/drive_control_status_word_tb.sv
// Bench for the command/state word block: decode, trip edge and state tests.
// Assumes the design files and the master model are compiled first.
`timescale 1ns/1ps
module drive_control_status_word_tb;
  import dcsw_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce = 1'b1;
  logic        cyc, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  dcsw_drv_t   drv_i = '0;
  dcsw_ctl_t   ctl_o;
  logic [15:0] sw;
  logic [15:0] cur_cmd = 16'h0000;
  logic [6:0]  cur_cfg = 7'h00;
  int          mismatches = 0;
  int          check_count = 0;
  int          pulses = 0;

  dcsw_core uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .drv_i(drv_i), .ctl_o(ctl_o), .state_word_o(sw));
  dcsw_wb_master m (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  always #2 clk_i = ~clk_i;
  // Trip reset is a one-cycle pulse, so count every edge it is seen
  always @(posedge clk_i) if (ctl_o.trip_reset === 1'b1) pulses++;

  function automatic dcsw_ctl_t exp_ctl(input logic [15:0] c, input logic [6:0] g,
                                        input logic di);
    dcsw_ctl_t e;
    e = '0;
    e.preset_idx = c[1:0];
    e.dc_brake = ~c[2];
    e.coast = ~c[3];
    e.quick_stop = ~c[4] & c[5];
    e.freeze = ~c[5];
    e.ramp_stop = ~c[6] & c[5];
    e.jog = c[8];
    e.ramp_set2 = c[9];
    e.relay1 = c[11] & g[0];
    e.relay2 = c[12] & g[1];
    e.setup_idx = g[2] ? c[14:13] : g[6:5];
    e.reverse = (g[4:3] == 2'd0) ? di : (g[4:3] == 2'd1) ? c[15] :
                (g[4:3] == 2'd2) ? (c[15] | di) : (c[15] & di);
    return e;
  endfunction

  function automatic logic [15:0] exp_sw(input dcsw_drv_t v, input logic c3);
    logic rdy;
    logic cst;
    rdy = v.ctrl_ready & ~v.tripped;
    cst = ~c3 | v.di_coast;
    if (v.link_lost) return 16'h0000;
    return {v.timer_over, v.torque_over, v.volt_bad, v.overtemp_hold,
            v.start_signal | v.freq_nonzero, v.freq_in_limits,
            ~v.local_ctrl & ~v.local_stop, v.speed_match, v.warning,
            v.triplock, 1'b0, v.error_no_trip, v.tripped,
            v.start_ready & ~cst, rdy & cst, rdy};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    m.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // Two spare edges let the decoded outputs catch up with the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    m.xfer(1'b1, a, d, q);
    repeat (2) @(posedge clk_i);
  endtask

  task automatic wcmd(input logic [15:0] c);
    wr(8'h00, {16'h0, c});
    if (c[10]) cur_cmd = c;
  endtask

  // Run permit and trip reset are left out: exp_ctl does not model them
  task automatic chk_ctl;
    dcsw_ctl_t k;
    dcsw_ctl_t e;
    k = ctl_o;
    k.run_permit = 1'b0;
    k.trip_reset = 1'b0;
    e = exp_ctl(cur_cmd, cur_cfg, drv_i.di_reverse);
    chk({16'h0, k}, {16'h0, e});
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    close_out;
  end

  initial begin
    logic [15:0] cw [8];
    logic [19:0] v;
    cw = '{16'h0400, 16'h047c, 16'h0441, 16'h0c3a, 16'h2e56, 16'h5e7d, 16'hfffe, 16'h8403};
    repeat (11) @(posedge clk_i);
    chk({ctl_o, sw}, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk_ctl;
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'h0);
    $display("reset test done");
    for (int j = 0; j < 4; j++) begin
      cur_cfg = {2'b10, j[1:0], j[0], j[1], ~j[1]};
      wr(8'h08, {25'h0, cur_cfg});
      rdc(8'h08, {25'h0, cur_cfg});
      for (int k = 0; k < 8; k++) begin
        drv_i.di_reverse <= k[0];
        wcmd(cw[k]);
        chk_ctl;
        rdc(8'h0c, {16'h0, cw[k]});
      end
    end
    rdc(8'h00, 32'h0);
    rdc(8'h10, 32'h0);
    $display("decode test done");
    wcmd(16'h03fb);
    chk_ctl;
    rdc(8'h0c, {16'h0, cw[7]});
    wcmd(16'h047c);
    pulses = 0;
    wcmd(16'h04fc);
    wcmd(16'h04fc);
    wcmd(16'h007c);
    wcmd(16'h04fc);
    chk(pulses, 1);
    wcmd(16'h047c);
    wcmd(16'h04fc);
    chk(pulses, 2);
    $display("trip reset test done");
    wcmd(16'h0474);
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 20; i++) begin
        v = (20'h1 << i) | (b == 1 ? 20'ha0000 : 20'h0);
        drv_i <= v;
        // Bit 2 follows the registered coast control, one edge behind
        repeat (3) @(posedge clk_i);
        chk({16'h0, sw}, {16'h0, exp_sw(v, cur_cmd[3])});
        rdc(8'h04, {16'h0, exp_sw(v, cur_cmd[3])});
      end
      wcmd(16'h047c);
    end
    $display("state test done");
    // Enable low must freeze the state word even when the link drops
    ce <= 1'b0;
    drv_i <= 20'h00008;
    repeat (3) @(posedge clk_i);
    chk({16'h0, sw}, {16'h0, exp_sw(v, cur_cmd[3])});
    ce <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({16'h0, sw}, 32'h0);
    $display("clock enable test done");
    close_out;
  end
endmodule
